// ---- core/ep0_dte_pkg.sv ----
package ep0_dte_pkg;

    // ==========================================================
    // Setup packet layout
    localparam int SETUP_BYTES = 8;
    localparam logic [2:0] SETUP_REQTYPE_IDX = 3'h0;
    localparam logic [2:0] SETUP_REQCODE_IDX = 3'h1;
    localparam logic [2:0] SETUP_LEN_LO_IDX = 3'h6;
    localparam logic [2:0] SETUP_LEN_HI_IDX = 3'h7;
    localparam logic [7:0] REQTYPE_STD_OUT_DEV = 8'h00;
    localparam logic [7:0] REQCODE_SET_DESC = 8'h07;

    // ==========================================================
    // Descriptor table and packets
    localparam logic [15:0] DESC_LEN_OFS = 16'h0000;
    localparam int EP0_PKT_MAX = 64;
    localparam int IN_BUF_DEPTH = 2;

    // ==========================================================
    // Reset values
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ==========================================================
    // Engine states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LEN = 6'h02,
        ST_FETCH = 6'h04,
        ST_HS = 6'h08,
        ST_STAT = 6'h10,
        ST_OUT = 6'h20
    } eng_state_t;

endpackage

// ---- core/ep0_byte_skid.sv ----
`timescale 1ns/1ps

module ep0_byte_skid #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_flush,
    // Filling side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Draining side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);

    // ==========================================================
    // Elaboration check
    generate
        if (DEPTH != 2 || WIDTH < 1) begin : g_bad
            $error("ep0_byte_skid serves exactly two entries");
        end
    endgenerate

    // ==========================================================
    // Head entry drives the outputs, spare catches a stalled push
    logic head_v_r;
    logic spare_v_r;
    logic [WIDTH-1:0] head_d_r;
    logic [WIDTH-1:0] spare_d_r;
    wire push = i_valid && !spare_v_r;
    wire pop = head_v_r && i_ready;
    wire head_free = !head_v_r || pop;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_flush) begin
            head_v_r <= 1'b0;
            spare_v_r <= 1'b0;
        end else if (head_free) begin
            head_v_r <= spare_v_r || push;
            spare_v_r <= spare_v_r && push;
        end else begin
            spare_v_r <= spare_v_r || push;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (head_free) begin
            head_d_r <= spare_v_r ? spare_d_r : i_data;
        end
        if (push && (spare_v_r || !head_free)) begin
            spare_d_r <= i_data;
        end
    end

    assign o_ready = !spare_v_r;
    assign o_valid = head_v_r;
    assign o_data = head_d_r;

endmodule

// ---- core/ep0_descriptor_transfer_engine.sv ----
`timescale 1ns/1ps

// Function
// R1 - Writing the pointer low byte starts the automatic IN data stage.
// R2 - Requested length comes from setup bytes 6 (low) and 7 (high).
// R3 - Descriptor length field at the pointer gives the actual size.
// R4 - Send the lesser length, bytes fetched sequentially from pointer.
// R5 - Split the stage into packets of at most 64 bytes.
// R6 - Resend a packet whenever the host does not acknowledge it.
// R7 - After the last packet, answer the status stage automatically.
// R8 - Firmware may use the pointer for any descriptor or vendor IN read.
// R9 - Short stages may instead be loaded manually with a byte count.
// R10 - Device descriptor read is 0x80/0x06 with type 0x01.
// R11 - Configuration read is 0x80/0x06 type 0x02, number in byte 2.
// R12 - Firmware picks the table from byte 2 and loads both pointer bytes.
// R13 - Descriptor write is 0x00/0x07, types 0x01, 0x02, 0x03.
// R14 - For descriptor write firmware clears handshake nak, reads OUT buffer.
// R15 - Count OUT bytes received and compare with setup bytes 6 and 7.
// R16 - When the count reaches the length, answer the status stage.
// R17 - Firmware re-arms the OUT endpoint after each packet.
// R18 - Store the eight setup bytes and raise the setup valid request.
// R19 - For descriptor read firmware clears nak, then loads the pointer.
// R20 - Firmware writes the high pointer byte before the low byte.
module ep0_descriptor_transfer_engine
    import ep0_dte_pkg::*;
#(
    parameter int PKT_SIZE = EP0_PKT_MAX
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Setup packet from the serial engine
    input wire logic i_setup_wr,
    input wire logic [2:0] i_setup_idx,
    input wire logic [7:0] i_setup_data,
    input wire logic i_setup_end,
    output logic o_setup_data_valid_irq,
    // Firmware strobes
    input wire logic i_ptr_high_wr,
    input wire logic i_ptr_low_wr,
    input wire logic [7:0] i_ptr_wdata,
    input wire logic i_handshake_nak_clr,
    output logic o_handshake_nak_bit,
    output logic [15:0] o_setup_data_pointer,
    output logic o_busy,
    // Descriptor RAM read port, data one cycle after o_ram_rd
    output logic o_ram_rd,
    output logic [15:0] o_ram_addr,
    input wire logic [7:0] i_ram_rdata,
    // IN byte stream toward the ep0 in buffer
    output logic o_in_valid,
    output logic [7:0] o_in_data,
    output logic o_in_last,
    input wire logic i_in_ready,
    input wire logic i_in_ack,
    input wire logic i_in_noack,
    // OUT data stage and status stage
    input wire logic i_out_byte,
    input wire logic i_status_done,
    output logic o_status_ack
);

    // ==========================================================
    // Elaboration check
    generate
        if (PKT_SIZE < 1 || PKT_SIZE > EP0_PKT_MAX) begin : g_bad
            $error("PKT_SIZE must lie in 1..64");
        end
    endgenerate

    // ==========================================================
    // Setup bytes storage
    logic [7:0] setup_bytes_ram [SETUP_BYTES];
    logic irq_r;

    always_ff @(posedge i_mclk) begin
        if (i_setup_wr) begin
            setup_bytes_ram[i_setup_idx] <= i_setup_data; // see R18
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= i_setup_end; // see R18
        end
    end

    wire [7:0] requested_length_low = setup_bytes_ram[SETUP_LEN_LO_IDX];
    wire [7:0] requested_length_high = setup_bytes_ram[SETUP_LEN_HI_IDX];
    wire [15:0] req_len = {requested_length_high, requested_length_low}; // see R2
    wire is_set_desc =
        setup_bytes_ram[SETUP_REQTYPE_IDX] == REQTYPE_STD_OUT_DEV &&
        setup_bytes_ram[SETUP_REQCODE_IDX] == REQCODE_SET_DESC;

    // ==========================================================
    // Pointer and handshake nak
    logic [7:0] ptr_high_r;
    logic [15:0] ptr_r;
    logic nak_r;
    wire [15:0] ptr_new = {ptr_high_r, i_ptr_wdata};

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ptr_high_r <= BYTE_RST;
            ptr_r <= PTR_RST;
            nak_r <= 1'b0;
        end else begin
            if (i_ptr_high_wr) begin
                ptr_high_r <= i_ptr_wdata;
            end
            if (i_ptr_low_wr) begin
                ptr_r <= ptr_new; // see R20
            end
            // A new setup wins over a clear in the same cycle
            nak_r <= i_setup_end || (nak_r && !i_handshake_nak_clr);
        end
    end

    // ==========================================================
    // Engine registers
    eng_state_t state_r, state_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] left_r, left_nxt;
    logic [15:0] pkt_addr_r, pkt_addr_nxt;
    logic [15:0] pkt_left_r, pkt_left_nxt;
    logic [6:0] pkt_cnt_r, pkt_cnt_nxt;
    logic [15:0] out_cnt_r, out_cnt_nxt;
    logic pend_r, dv_r, ram_rd_r;
    logic [15:0] ram_addr_r;
    logic stat_r;

    logic fifo_ready;
    wire start = i_ptr_low_wr && !i_setup_end; // see R1
    wire [15:0] desc_len = {8'h00, i_ram_rdata};
    wire [15:0] total = (req_len < desc_len) ? req_len : desc_len; // see R4
    wire pkt_end = pkt_cnt_r == 7'(PKT_SIZE - 1); // see R5
    wire byte_last = pkt_end || left_r == 16'h0001;
    wire issue = start || (state_r == ST_FETCH && !pend_r && fifo_ready);
    wire push = state_r == ST_FETCH && dv_r;
    wire [15:0] out_cnt_inc = out_cnt_r + 16'h0001;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        left_nxt = left_r;
        pkt_addr_nxt = pkt_addr_r;
        pkt_left_nxt = pkt_left_r;
        pkt_cnt_nxt = pkt_cnt_r;
        out_cnt_nxt = out_cnt_r;
        if (i_setup_end) begin
            out_cnt_nxt = 16'h0000;
            if (!is_set_desc) begin
                state_nxt = ST_IDLE;
            end else if (req_len == 16'h0000) begin
                state_nxt = ST_STAT; // see R16
            end else begin
                state_nxt = ST_OUT; // see R15
            end
        end else if (start) begin
            state_nxt = ST_LEN; // see R1
        end else begin
            case (state_r)
                ST_IDLE: begin
                end
                ST_LEN: begin
                    if (dv_r) begin
                        addr_nxt = ptr_r; // see R3
                        left_nxt = total;
                        pkt_addr_nxt = ptr_r;
                        pkt_left_nxt = total;
                        pkt_cnt_nxt = 7'h00;
                        state_nxt = (total == 16'h0000) ? ST_STAT : ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (push) begin
                        addr_nxt = addr_r + 16'h0001; // see R4
                        left_nxt = left_r - 16'h0001;
                        pkt_cnt_nxt = pkt_cnt_r + 7'h01;
                        if (byte_last) begin
                            pkt_cnt_nxt = 7'h00;
                            state_nxt = ST_HS; // see R5
                        end
                    end
                end
                ST_HS: begin
                    if (i_in_noack) begin
                        addr_nxt = pkt_addr_r; // see R6
                        left_nxt = pkt_left_r;
                        state_nxt = ST_FETCH;
                    end else if (i_in_ack) begin
                        pkt_addr_nxt = addr_r;
                        pkt_left_nxt = left_r;
                        state_nxt = (left_r == 16'h0000) ? ST_STAT : ST_FETCH; // see R7
                    end
                end
                ST_STAT: begin
                    if (i_status_done) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_OUT: begin
                    if (i_out_byte) begin
                        out_cnt_nxt = out_cnt_inc; // see R15
                        if (out_cnt_inc >= req_len) begin
                            state_nxt = ST_STAT; // see R16
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_r <= ST_IDLE;
            addr_r <= PTR_RST;
            left_r <= PTR_RST;
            pkt_addr_r <= PTR_RST;
            pkt_left_r <= PTR_RST;
            pkt_cnt_r <= 7'h00;
            out_cnt_r <= PTR_RST;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            left_r <= left_nxt;
            pkt_addr_r <= pkt_addr_nxt;
            pkt_left_r <= pkt_left_nxt;
            pkt_cnt_r <= pkt_cnt_nxt;
            out_cnt_r <= out_cnt_nxt;
        end
    end

    // ==========================================================
    // RAM read timing; one byte in flight keeps buffer room honest
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_setup_end) begin
            ram_rd_r <= 1'b0;
            dv_r <= 1'b0;
            pend_r <= 1'b0;
            ram_addr_r <= PTR_RST;
            stat_r <= 1'b0;
        end else begin
            ram_rd_r <= issue;
            dv_r <= ram_rd_r;
            pend_r <= issue || (pend_r && !dv_r);
            if (issue) begin
                ram_addr_r <= start ? ptr_new + DESC_LEN_OFS : addr_r; // see R3
            end
            stat_r <= state_nxt == ST_STAT; // see R7
        end
    end

    // ==========================================================
    // Two-entry buffer toward the IN endpoint; a stall loses no byte
    ep0_byte_skid #(
        .WIDTH(9),
        .DEPTH(IN_BUF_DEPTH)
    ) u_in_buf (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_flush(i_setup_end || start),
        .i_valid(push),
        .i_data({byte_last, i_ram_rdata}),
        .o_ready(fifo_ready),
        .o_valid(o_in_valid),
        .o_data({o_in_last, o_in_data}),
        .i_ready(i_in_ready)
    );

    // ==========================================================
    // Outputs
    logic busy_r;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= state_nxt != ST_IDLE;
        end
    end

    assign o_setup_data_valid_irq = irq_r;
    assign o_handshake_nak_bit = nak_r;
    assign o_setup_data_pointer = ptr_r;
    assign o_busy = busy_r;
    assign o_ram_rd = ram_rd_r;
    assign o_ram_addr = ram_addr_r;
    assign o_status_ack = stat_r;

endmodule

// ---- bench/ep0_dte_monitor.sv ----
`timescale 1ns/1ps
// ==========================================================
// Port checker
module ep0_dte_monitor #(
    parameter int PKT_SIZE = 64
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Setup and pointer
    input wire logic i_setup_wr,
    input wire logic [2:0] i_setup_idx,
    input wire logic [7:0] i_setup_data,
    input wire logic i_setup_end,
    input wire logic o_setup_data_valid_irq,
    input wire logic o_handshake_nak_bit,
    input wire logic i_ptr_low_wr,
    input wire logic [15:0] o_setup_data_pointer,
    // Data and status
    input wire logic o_ram_rd,
    input wire logic [15:0] o_ram_addr,
    input wire logic o_in_valid,
    input wire logic [7:0] o_in_data,
    input wire logic o_in_last,
    input wire logic i_in_ready,
    input wire logic i_in_noack,
    input wire logic i_out_byte,
    input wire logic o_status_ack
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    logic [6:0] pcnt_r;
    logic [15:0] len_r, ocnt_r;
    logic [7:0] b0_r, b1_r;
    logic wr_r;
    wire acc = o_in_valid && i_in_ready;
    wire wr_req = (b0_r == 8'h00) && (b1_r == 8'h07);
    // Restarts on flush or resend, since a packet is refetched whole
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_setup_end || i_ptr_low_wr || i_in_noack) begin
            pcnt_r <= 7'h00;
        end else if (acc) begin
            pcnt_r <= o_in_last ? 7'h00 : pcnt_r + 7'h01;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_setup_wr) begin
            case (i_setup_idx)
                3'h0: b0_r <= i_setup_data;
                3'h1: b1_r <= i_setup_data;
                3'h6: len_r[7:0] <= i_setup_data;
                3'h7: len_r[15:8] <= i_setup_data;
                default: ;
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_ptr_low_wr) begin
            wr_r <= 1'b0;
            ocnt_r <= 16'h0000;
        end else if (i_setup_end) begin
            wr_r <= wr_req;
            ocnt_r <= 16'h0000;
        end else if (wr_r && i_out_byte) begin
            ocnt_r <= ocnt_r + 16'h0001;
        end
    end
    // ==========================================================
    // Assertions
    irq_pulse_a: assert property (
        o_setup_data_valid_irq == $past(i_setup_end))
        else $error("setup irq not one cycle after setup end");
    nak_set_a: assert property (
        i_setup_end |=> o_handshake_nak_bit)
        else $error("nak bit not set by setup");
    ptr_start_a: assert property (
        i_ptr_low_wr && !i_setup_end |=>
        o_ram_rd && o_ram_addr == o_setup_data_pointer)
        else $error("low pointer write did not fetch length");
    pkt_last_a: assert property (
        acc |-> (pcnt_r < PKT_SIZE - 1) || o_in_last)
        else $error("packet longer than packet size");
    in_hold_a: assert property (
        o_in_valid && !i_in_ready && !i_setup_end && !i_ptr_low_wr
        |=> o_in_valid && $stable(o_in_data) && $stable(o_in_last))
        else $error("in byte changed while stalled");
    noack_refetch_a: assert property (
        i_in_noack |-> ##[1:3] o_ram_rd)
        else $error("no refetch after missing ack");
    out_done_a: assert property (
        wr_r && i_out_byte && ocnt_r + 16'h0001 == len_r
        |-> ##[1:2] o_status_ack)
        else $error("no status ack at full count");
    out_early_a: assert property (
        wr_r && ocnt_r < len_r |-> !o_status_ack)
        else $error("status ack before full count");
    cover property (i_in_noack);
    cover property (acc && o_in_last);
    cover property (wr_r && $rose(o_status_ack));
endmodule

bind ep0_descriptor_transfer_engine ep0_dte_monitor #(
    .PKT_SIZE(PKT_SIZE)
) i_mon (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_setup_wr(i_setup_wr),
    .i_setup_idx(i_setup_idx), .i_setup_data(i_setup_data),
    .i_setup_end(i_setup_end),
    .o_setup_data_valid_irq(o_setup_data_valid_irq),
    .o_handshake_nak_bit(o_handshake_nak_bit),
    .i_ptr_low_wr(i_ptr_low_wr),
    .o_setup_data_pointer(o_setup_data_pointer),
    .o_ram_rd(o_ram_rd), .o_ram_addr(o_ram_addr),
    .o_in_valid(o_in_valid), .o_in_data(o_in_data),
    .o_in_last(o_in_last), .i_in_ready(i_in_ready),
    .i_in_noack(i_in_noack), .i_out_byte(i_out_byte),
    .o_status_ack(o_status_ack)
);

// ---- bench/ep0_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host and descriptor memory
module ep0_host_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Scenario controls
    input wire logic [15:0] i_base,
    input wire logic [7:0] i_dlen,
    input wire logic i_stall,
    input wire logic i_nack,
    // Engine side
    input wire logic i_rd,
    input wire logic [15:0] i_addr,
    input wire logic i_valid,
    input wire logic i_last,
    input wire logic i_stat,
    output logic [7:0] o_rdata,
    output logic o_ready,
    output logic o_ack,
    output logic o_noack,
    output logic o_done
);
    logic [1:0] tk_r;
    logic [2:0] gap_r;
    logic nk_r, sd_r;
    assign o_ready = !(i_stall && tk_r == 2'h3);
    always_ff @(posedge i_mclk) begin
        tk_r <= tk_r + 2'h1;
        // Idle read data toggles so a late sample cannot pass
        o_rdata <= !i_rd ? ~o_rdata :
            (i_addr == i_base) ? i_dlen : i_addr[7:0] ^ 8'h5A;
        o_ack <= 1'b0;
        o_noack <= 1'b0;
        sd_r <= i_stat;
        o_done <= i_stat && sd_r && !o_done;
        if (i_valid && o_ready && i_last) gap_r <= 3'h3;
        else if (gap_r != 3'h0) gap_r <= gap_r - 3'h1;
        if (gap_r == 3'h1 && i_nack && !nk_r) begin
            o_noack <= 1'b1;
            nk_r <= 1'b1;
        end else if (gap_r == 3'h1) begin
            o_ack <= 1'b1;
        end
        if (!i_nrst || i_stat) nk_r <= 1'b0;
        if (!i_nrst) gap_r <= 3'h0;
        // Stall pacing must start known or ready goes unknown
        if (!i_nrst) tk_r <= 2'h0;
    end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import ep0_dte_pkg::*;
    logic i_mclk = 1'b0;
    logic i_nrst, setup_wr, setup_end, ptr_hi, ptr_lo, nak_clr;
    logic out_byte, stall, nack, in_ready, in_ack, in_noack, stat_done;
    logic irq, nak, busy, ram_rd, in_valid, in_last, stat_ack;
    logic [2:0] setup_idx;
    logic [7:0] setup_data, ptr_wdata, dlen, rdata, in_data;
    logic [15:0] base, ptr, ram_addr;
    logic [7:0] pkt_q[$];
    logic [7:0] got_q[$];
    int n_errors, tests_run, max_pkt;
    always #50 i_mclk = ~i_mclk;
    ep0_descriptor_transfer_engine i_dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_setup_wr(setup_wr),
        .i_setup_idx(setup_idx), .i_setup_data(setup_data),
        .i_setup_end(setup_end), .o_setup_data_valid_irq(irq),
        .i_ptr_high_wr(ptr_hi), .i_ptr_low_wr(ptr_lo),
        .i_ptr_wdata(ptr_wdata), .i_handshake_nak_clr(nak_clr),
        .o_handshake_nak_bit(nak), .o_setup_data_pointer(ptr),
        .o_busy(busy), .o_ram_rd(ram_rd), .o_ram_addr(ram_addr),
        .i_ram_rdata(rdata), .o_in_valid(in_valid), .o_in_data(in_data),
        .o_in_last(in_last), .i_in_ready(in_ready), .i_in_ack(in_ack),
        .i_in_noack(in_noack), .i_out_byte(out_byte),
        .i_status_done(stat_done), .o_status_ack(stat_ack));
    ep0_host_model i_host (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_base(base), .i_dlen(dlen),
        .i_stall(stall), .i_nack(nack), .i_rd(ram_rd), .i_addr(ram_addr),
        .i_valid(in_valid), .i_last(in_last), .i_stat(stat_ack),
        .o_rdata(rdata), .o_ready(in_ready), .o_ack(in_ack),
        .o_noack(in_noack), .o_done(stat_done));
    // Bytes count only once their packet is acknowledged
    always @(posedge i_mclk) begin
        if (in_valid && in_ready) pkt_q.push_back(in_data);
        if (in_noack) pkt_q.delete();
        if (in_ack) begin
            if (pkt_q.size() > max_pkt) max_pkt = pkt_q.size();
            got_q = {got_q, pkt_q};
            pkt_q.delete();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_on(input bit idle);
        int k;
        k = 0;
        while ((idle ? busy !== 1'b0 : stat_ack !== 1'b1) && k < 4000) begin
            @(negedge i_mclk);
            k++;
        end
        if (k == 4000) begin
            check(16'(k), 16'h0000);
            close_out();
        end
    endtask
    task automatic send_setup(input logic [7:0] rt, rc, vh,
                              input logic [15:0] len);
        logic [7:0] b [8];
        b = '{rt, rc, 8'h00, vh, 8'h00, 8'h00, len[7:0], len[15:8]};
        for (int i = 0; i < 8; i++) begin
            @(negedge i_mclk);
            setup_wr = 1'b1;
            setup_idx = i[2:0];
            setup_data = b[i];
        end
        @(negedge i_mclk);
        setup_wr = 1'b0;
        setup_end = 1'b1;
        @(negedge i_mclk);
        setup_end = 1'b0;
        check({irq, nak}, 16'h0003);
        nak_clr = 1'b1;
        @(negedge i_mclk);
        nak_clr = 1'b0;
        check(nak, 1'b0);
    endtask
    task automatic run_in(input string nm, input logic [15:0] p, req,
                          input logic [7:0] dl, vh, input logic nk, st);
        int tot;
        logic [15:0] a;
        tot = (req < dl) ? req : dl;
        base = p;
        dlen = dl;
        nack = nk;
        stall = st;
        got_q.delete();
        max_pkt = 0;
        send_setup(8'h80, 8'h06, vh, req);
        @(negedge i_mclk);
        ptr_hi = 1'b1;
        ptr_wdata = p[15:8];
        @(negedge i_mclk);
        ptr_hi = 1'b0;
        ptr_lo = 1'b1;
        ptr_wdata = p[7:0];
        @(negedge i_mclk);
        ptr_lo = 1'b0;
        check(ptr, p);
        wait_on(1'b0);
        check(stat_ack, 1'b1);
        check(16'(got_q.size()), 16'(tot));
        check(16'(max_pkt), 16'(tot > EP0_PKT_MAX ? EP0_PKT_MAX : tot));
        for (int i = 0; i < tot; i++) begin
            a = p + 16'(i);
            check(got_q[i], i == 0 ? dl : a[7:0] ^ 8'h5A);
        end
        wait_on(1'b1);
        $display("test %s done", nm);
    endtask
    // A new setup in mid-stage must abort the stage and flush the buffer
    task automatic test_abort;
        base = 16'h5500;
        dlen = 8'hFF;
        send_setup(8'h80, 8'h06, 8'h01, 16'h00FF);
        @(negedge i_mclk);
        ptr_hi = 1'b1;
        ptr_wdata = 8'h55;
        @(negedge i_mclk);
        ptr_hi = 1'b0;
        ptr_lo = 1'b1;
        ptr_wdata = 8'h00;
        @(negedge i_mclk);
        ptr_lo = 1'b0;
        repeat (12) @(negedge i_mclk);
        check(busy, 1'b1);
        send_setup(8'h80, 8'h06, 8'h01, 16'h0012);
        check({busy, in_valid, stat_ack}, 16'h0000);
        pkt_q.delete();
        $display("test abort done");
    endtask
    task automatic test_set_desc;
        // Length zero goes straight to the status stage
        for (int t = 0; t <= 3; t++) begin
            send_setup(8'h00, 8'h07, 8'(t % 3 + 1), t[15:0]);
            for (int k = 0; k < t; k++) begin
                check(stat_ack, 1'b0);
                out_byte = 1'b1;
                @(negedge i_mclk);
                out_byte = 1'b0;
                @(negedge i_mclk);
            end
            wait_on(1'b0);
            check(stat_ack, 1'b1);
            wait_on(1'b1);
        end
        $display("test set_desc done");
    endtask
    initial begin
        {i_nrst, setup_wr, setup_end, ptr_hi, ptr_lo, nak_clr} = '0;
        {out_byte, stall, nack, setup_idx} = '0;
        {setup_data, ptr_wdata, dlen, base} = '0;
        repeat (20) @(negedge i_mclk);
        i_nrst = 1'b1;
        @(negedge i_mclk);
        check({busy, irq, in_valid, stat_ack}, 16'h0000);
        run_in("long_retry", 16'h1234, 16'h0064, 8'h46, 8'h01, 1, 1);
        run_in("short", 16'h20FE, 16'h0005, 8'h46, 8'h02, 0, 0);
        run_in("full_pkt", 16'h3300, 16'h0040, 8'hC8, 8'h03, 0, 1);
        run_in("zero", 16'h4400, 16'h0000, 8'h12, 8'h01, 0, 0);
        test_abort();
        test_set_desc();
        close_out();
    end
endmodule
